/* File: verilog/sdcur_regs.sv */
// second display cursor register bank behind an ahb-lite slave
// Functional notes
// - sign bit set means negative vertical position; software keeps magnitude within 63.
// - vertical coordinate is 10 bits: low byte plus two upper bits, in pixels.
// - vertical position is used only in cursor mode; otherwise it has no effect.
// - x bytes and low y byte wait for high y write, then next blank.
// - high y byte write takes effect at the next vertical non-display period.
// - colour 0 held as 5-bit blue, 6-bit green, 5-bit red registers.
// - colour 1 held as 5-bit blue, 6-bit green, 5-bit red registers.
// - programmed fifo high threshold steers cursor layer memory arbitration.
// - threshold register of zero selects an automatic hardware threshold.
// - two-bit mode: 00 inactive, 01 cursor, 10 ink, 11 reserved.
`timescale 1ns/1ps
module sdcur_regs (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic vblank,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  output logic cursor_en,
  output logic ink_en,
  output logic second_display_vertical_sign,
  output logic [9:0] second_display_vertical_coord,
  output logic [10:0] vertical_pos_signed,
  output logic horizontal_sign,
  output logic [9:0] horizontal_coord,
  output logic [4:0] colour0_blue,
  output logic [5:0] colour0_green,
  output logic [4:0] colour0_red,
  output logic [4:0] colour1_blue,
  output logic [5:0] colour1_green,
  output logic [4:0] colour1_red,
  output logic [5:0] fifo_high_threshold,
  output logic fifo_threshold_auto
);
  import sdcur_pkg::*;

  typedef struct packed {
    logic dp_wr;
    logic dp_sel;
    logic [7:0] dp_idx;
    logic [1:0] mode;
    logic [7:0] xlo;
    logic [7:0] xhi;
    logic [7:0] ylo;
    logic [7:0] yhi;
    logic [1:0][4:0] cb;
    logic [1:0][5:0] cg;
    logic [1:0][4:0] cr;
    logic [5:0] thr;
    logic commit;
    logic [31:0] rdata;
    logic [5:0] thr_eff;
    logic thr_auto;
    logic cur_en;
    logic ink_en;
    logic ysign;
    logic [9:0] ycoord;
    logic [10:0] ysigned;
    logic xsign;
    logic [9:0] xcoord;
  } sdcur_regs_t;

  sdcur_regs_t q;
  sdcur_regs_t n;
  logic [10:0] act_x;
  logic [10:0] act_y;
  logic pend;
  logic addr_ok;
  logic aphase;

  // word-aligned hit on one register index; upper address bits must be zero
  function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] want);
    reg_hit = (idx == want);
  endfunction : reg_hit

  assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  assign aphase = hsel && htrans[1] && hready;

  always_comb begin
    n = q;
    n.commit = 1'b0;
    // data phase of a write: only used bits are stored
    if (q.dp_wr && q.dp_sel) begin
      if (reg_hit(q.dp_idx, SDCUR_IDX_MODE)) begin
        n.mode = hwdata[1:0];
      end
      if (reg_hit(q.dp_idx, SDCUR_IDX_XLO)) begin
        n.xlo = hwdata[7:0];
      end
      if (reg_hit(q.dp_idx, SDCUR_IDX_XHI)) begin
        n.xhi = hwdata[7:0] & SDCUR_HI_MASK;
      end
      if (reg_hit(q.dp_idx, SDCUR_IDX_YLO)) begin
        n.ylo = hwdata[7:0];
      end
      if (reg_hit(q.dp_idx, SDCUR_IDX_YHI)) begin
        n.yhi = hwdata[7:0] & SDCUR_HI_MASK;
        n.commit = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (reg_hit(q.dp_idx, SDCUR_IDX_C0B + 8'(i) * SDCUR_COL_STRIDE)) begin
          n.cb[i] = hwdata[4:0];
        end
        if (reg_hit(q.dp_idx, SDCUR_IDX_C0G + 8'(i) * SDCUR_COL_STRIDE)) begin
          n.cg[i] = hwdata[5:0];
        end
        if (reg_hit(q.dp_idx, SDCUR_IDX_C0R + 8'(i) * SDCUR_COL_STRIDE)) begin
          n.cr[i] = hwdata[4:0];
        end
      end
      if (reg_hit(q.dp_idx, SDCUR_IDX_THR)) begin
        n.thr = hwdata[5:0];
      end
    end
    // address phase; reads look at the post-write image so back to back works
    n.dp_wr = aphase && hwrite;
    n.dp_sel = aphase && addr_ok;
    n.dp_idx = haddr[9:2];
    if (aphase && !hwrite) begin
      n.rdata = 32'h00000000;
      if (addr_ok) begin
        unique case (haddr[9:2])
          SDCUR_IDX_MODE: n.rdata[1:0] = n.mode;
          SDCUR_IDX_XLO: n.rdata[7:0] = n.xlo;
          SDCUR_IDX_XHI: n.rdata[7:0] = n.xhi;
          SDCUR_IDX_YLO: n.rdata[7:0] = n.ylo;
          SDCUR_IDX_YHI: n.rdata[7:0] = n.yhi;
          SDCUR_IDX_C0B: n.rdata[4:0] = n.cb[0];
          SDCUR_IDX_C0G: n.rdata[5:0] = n.cg[0];
          SDCUR_IDX_C0R: n.rdata[4:0] = n.cr[0];
          SDCUR_IDX_C1B: n.rdata[4:0] = n.cb[1];
          SDCUR_IDX_C1G: n.rdata[5:0] = n.cg[1];
          SDCUR_IDX_C1R: n.rdata[4:0] = n.cr[1];
          SDCUR_IDX_THR: n.rdata[5:0] = n.thr;
          SDCUR_IDX_STAT: n.rdata[0] = pend;
          default: n.rdata = 32'h00000000;
        endcase
      end
    end
    // threshold used by the memory arbiter
    n.thr_auto = (q.thr == SDCUR_RST_THR);
    n.thr_eff = n.thr_auto ? SDCUR_THR_AUTO : q.thr;
    n.cur_en = (q.mode == SDCUR_MODE_CURSOR);
    n.ink_en = (q.mode == SDCUR_MODE_INK);
    // reserved mode 11 behaves as inactive
    if (q.mode == SDCUR_MODE_CURSOR) begin
      n.ysign = act_y[10];
      n.ycoord = act_y[9:0];
      n.xsign = act_x[10];
      n.xcoord = act_x[9:0];
    end else begin
      n.ysign = 1'b0;
      n.ycoord = 10'h000;
      n.xsign = 1'b0;
      n.xcoord = 10'h000;
    end
    // magnitude above 63 when negative is software's to avoid
    n.ysigned = n.ysign ? 11'(-{1'b0, n.ycoord}) : {1'b0, n.ycoord};
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.mode <= SDCUR_RST_MODE;
      q.thr <= SDCUR_RST_THR;
      q.xlo <= SDCUR_RST_BYTE;
      q.xhi <= SDCUR_RST_BYTE;
      q.ylo <= SDCUR_RST_BYTE;
      q.yhi <= SDCUR_RST_BYTE;
      q.thr_eff <= SDCUR_THR_AUTO;
      q.thr_auto <= 1'b1;
    end else begin
      q <= n;
    end
  end

  sdcur_stage u_stage (
    .mclk(mclk),
    .rstn(rstn),
    .commit_req(q.commit),
    .shadow_x({q.xhi[SDCUR_SIGN_BIT], q.xhi[1:0], q.xlo}),
    .shadow_y({q.yhi[SDCUR_SIGN_BIT], q.yhi[1:0], q.ylo}),
    .vblank(vblank),
    .active_x(act_x),
    .active_y(act_y),
    .pending(pend)
  );

  // zero wait state slave: ready and okay are constant flops
  logic rdy_q;
  logic [1:0] resp_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdy_q <= 1'b1;
      resp_q <= SDCUR_HRESP_OKAY;
    end else begin
      rdy_q <= 1'b1;
      resp_q <= SDCUR_HRESP_OKAY;
    end
  end
  assign hreadyout = rdy_q;
  assign hresp = resp_q;
  assign hrdata = q.rdata;
  assign cursor_en = q.cur_en;
  assign ink_en = q.ink_en;
  assign second_display_vertical_sign = q.ysign;
  assign second_display_vertical_coord = q.ycoord;
  assign vertical_pos_signed = q.ysigned;
  assign horizontal_sign = q.xsign;
  assign horizontal_coord = q.xcoord;
  assign colour0_blue = q.cb[0];
  assign colour0_green = q.cg[0];
  assign colour0_red = q.cr[0];
  assign colour1_blue = q.cb[1];
  assign colour1_green = q.cg[1];
  assign colour1_red = q.cr[1];
  assign fifo_high_threshold = q.thr_eff;
  assign fifo_threshold_auto = q.thr_auto;

  property p_thr_auto;
    @(posedge mclk) disable iff (!rstn)
    q.thr == 6'h00 |=> fifo_high_threshold == 6'h08 && fifo_threshold_auto;
  endproperty
  a_thr_auto: assert property (p_thr_auto) else $error("auto threshold not chosen");

  property p_thr_prog;
    @(posedge mclk) disable iff (!rstn)
    q.thr != 6'h00 |=> fifo_high_threshold == $past(q.thr) && !fifo_threshold_auto;
  endproperty
  a_thr_prog: assert property (p_thr_prog) else $error("programmed threshold lost");

  property p_mode_gate;
    @(posedge mclk) disable iff (!rstn)
    q.mode != 2'h1 |=> second_display_vertical_coord == 10'h000 && !second_display_vertical_sign;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("position leaks outside cursor");

  property p_coord;
    @(posedge mclk) disable iff (!rstn)
    q.mode == 2'h1 |=> second_display_vertical_coord == $past(act_y[9:0]);
  endproperty
  a_coord: assert property (p_coord) else $error("vertical coordinate wrong");

  property p_signed;
    @(posedge mclk) disable iff (!rstn)
    second_display_vertical_sign |->
      11'(vertical_pos_signed + {1'b0, second_display_vertical_coord}) == 11'h000;
  endproperty
  a_signed: assert property (p_signed) else $error("negative position wrong");

  sequence s_wr(logic [7:0] idx);
    aphase && hwrite && addr_ok && haddr[9:2] == idx;
  endsequence
  property p_col0;
    @(posedge mclk) disable iff (!rstn)
    s_wr(8'h86) ##1 1'b1 |=> colour0_blue == $past(hwdata[4:0]);
  endproperty
  a_col0: assert property (p_col0) else $error("colour 0 blue not stored");

  property p_col1;
    @(posedge mclk) disable iff (!rstn)
    s_wr(8'h8B) ##1 1'b1 |=> colour1_green == $past(hwdata[5:0]);
  endproperty
  a_col1: assert property (p_col1) else $error("colour 1 green not stored");

  property p_unused;
    @(posedge mclk) disable iff (!rstn)
    aphase && !hwrite && addr_ok && haddr[9:2] == 8'h85 |=> hrdata[31:8] == 24'h000000
      && hrdata[6:2] == 5'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits read nonzero");

  property p_mode_dec;
    @(posedge mclk) disable iff (!rstn)
    q.mode == 2'h2 |=> ink_en && !cursor_en;
  endproperty
  a_mode_dec: assert property (p_mode_dec) else $error("ink mode not decoded");

  property p_commit;
    @(posedge mclk) disable iff (!rstn)
    s_wr(8'h85) |=> ##1 q.commit ##1 pend;
  endproperty
  a_commit: assert property (p_commit) else $error("high byte write did not arm");

  property p_unmapped;
    @(posedge mclk) disable iff (!rstn)
    aphase && !hwrite && haddr[9:2] == 8'h81 |=> hrdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

  property p_status;
    @(posedge mclk) disable iff (!rstn)
    aphase && !hwrite && addr_ok && haddr[9:2] == SDCUR_IDX_STAT
      |=> hrdata[0] == $past(pend);
  endproperty
  a_status: assert property (p_status) else $error("pending status wrong");
endmodule : sdcur_regs

/* File: verilog/sdcur_pkg.sv */
// constants for the second display cursor register bank
package sdcur_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] SDCUR_IDX_MODE = 8'h80;
  localparam logic [7:0] SDCUR_IDX_XLO = 8'h82;
  localparam logic [7:0] SDCUR_IDX_XHI = 8'h83;
  localparam logic [7:0] SDCUR_IDX_YLO = 8'h84;
  localparam logic [7:0] SDCUR_IDX_YHI = 8'h85;
  localparam logic [7:0] SDCUR_IDX_C0B = 8'h86;
  localparam logic [7:0] SDCUR_IDX_C0G = 8'h87;
  localparam logic [7:0] SDCUR_IDX_C0R = 8'h88;
  localparam logic [7:0] SDCUR_IDX_C1B = 8'h8A;
  localparam logic [7:0] SDCUR_IDX_C1G = 8'h8B;
  localparam logic [7:0] SDCUR_IDX_C1R = 8'h8C;
  localparam logic [7:0] SDCUR_IDX_THR = 8'h8E;
  localparam logic [7:0] SDCUR_IDX_STAT = 8'h90;
  // colour set stride in index units
  localparam logic [7:0] SDCUR_COL_STRIDE = 8'h04;
  // field positions and masks
  localparam int SDCUR_SIGN_BIT = 7;
  localparam logic [7:0] SDCUR_HI_MASK = 8'h83;
  localparam logic [1:0] SDCUR_MODE_OFF = 2'h0;
  localparam logic [1:0] SDCUR_MODE_CURSOR = 2'h1;
  localparam logic [1:0] SDCUR_MODE_INK = 2'h2;
  // reset values
  localparam logic [7:0] SDCUR_RST_BYTE = 8'h00;
  localparam logic [1:0] SDCUR_RST_MODE = 2'h0;
  localparam logic [5:0] SDCUR_RST_THR = 6'h00;
  // threshold used when software leaves the register at zero
  localparam logic [5:0] SDCUR_THR_AUTO = 6'h08;
  localparam logic [1:0] SDCUR_HRESP_OKAY = 2'h0;
endpackage : sdcur_pkg

/* File: verilog/sdcur_stage.sv */
// staged position update committed at vertical non-display
`timescale 1ns/1ps
module sdcur_stage (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic commit_req,
  input wire logic [10:0] shadow_x,
  input wire logic [10:0] shadow_y,
  input wire logic vblank,
  output logic [10:0] active_x,
  output logic [10:0] active_y,
  output logic pending
);
  import sdcur_pkg::*;

  typedef struct packed {
    logic vblank;
    logic pend;
    logic [10:0] ax;
    logic [10:0] ay;
  } sdcur_stage_t;

  sdcur_stage_t st_q;
  sdcur_stage_t st_d;
  logic rise;

  assign rise = vblank && !st_q.vblank;

  always_comb begin
    st_d = st_q;
    st_d.vblank = vblank;
    // only the start of a non-display period commits, never mid-frame
    if (rise && st_q.pend) begin
      st_d.ax = shadow_x;
      st_d.ay = shadow_y;
    end
    // a new high-byte write in the commit cycle stays pending
    st_d.pend = commit_req || (st_q.pend && !rise);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active_x = st_q.ax;
  assign active_y = st_q.ay;
  assign pending = st_q.pend;

  property p_hold;
    @(posedge mclk) disable iff (!rstn)
    !(rise && st_q.pend) |=> $stable(st_q.ay) && $stable(st_q.ax);
  endproperty
  a_hold: assert property (p_hold) else $error("position moved without commit");

  sequence s_armed;
    st_q.pend && !commit_req;
  endsequence
  property p_apply;
    @(posedge mclk) disable iff (!rstn)
    s_armed ##0 rise |=> st_q.ay == $past(shadow_y) && st_q.ax == $past(shadow_x)
      && !st_q.pend;
  endproperty
  a_apply: assert property (p_apply) else $error("staged position not applied");
endmodule : sdcur_stage

/* File: tb/sdcur_regs_tb.sv */
// self-checking bench for the second display cursor register bank
`timescale 1ns/1ps
module sdcur_regs_tb;
  import sdcur_pkg::*;
  logic mclk, rstn, hsel, hwrite, hready, vblank;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic hreadyout, cursor_en, ink_en, vsign, hsign, auto_thr;
  logic [9:0] vcoord, hcoord;
  logic [10:0] vsigned;
  logic [4:0] c0b, c0r, c1b, c1r;
  logic [5:0] c0g, c1g, thr;
  logic [31:0] seed = 32'h5C6CE022;
  int fails = 0;
  int n_compared = 0;
  logic [7:0] cidx [6] = '{SDCUR_IDX_C0B, SDCUR_IDX_C0G, SDCUR_IDX_C0R,
                           SDCUR_IDX_C1B, SDCUR_IDX_C1G, SDCUR_IDX_C1R};
  logic [7:0] cmsk [6] = '{8'h1F, 8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h1F};
  logic [7:0] v, ylo, yhi;
  logic a_s;
  logic [9:0] a_m;
  sdcur_regs i_sdcur_regs (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .vblank(vblank), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .cursor_en(cursor_en), .ink_en(ink_en), .second_display_vertical_sign(vsign),
    .second_display_vertical_coord(vcoord), .vertical_pos_signed(vsigned),
    .horizontal_sign(hsign), .horizontal_coord(hcoord), .colour0_blue(c0b),
    .colour0_green(c0g), .colour0_red(c0r), .colour1_blue(c1b), .colour1_green(c1g),
    .colour1_red(c1r), .fifo_high_threshold(thr), .fifo_threshold_auto(auto_thr));
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [10:0] exp_signed(input logic s, input logic [9:0] m);
    return s ? -{1'b0, m} : {1'b0, m};
  endfunction : exp_signed
  function automatic logic [7:0] col_out(input int k);
    case (k)
      0: return {3'h0, c0b};
      1: return {2'h0, c0g};
      2: return {3'h0, c0r};
      3: return {3'h0, c1b};
      4: return {2'h0, c1g};
      default: return {3'h0, c1r};
    endcase
  endfunction : col_out
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // address phase held until ready, then data phase held until ready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1 && n++ < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1 && n++ < 100);
    q = hrdata;
    if (n >= 50) chk("bus wait", 32'h1, 32'h0);
  endtask : xfer
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, {rnd() & 32'hFFFFFF00} | d, rd);
  endtask : wr
  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic chk_vert(input logic s, input logic [9:0] m);
    chk("vsign", vsign, s);
    chk("vcoord", vcoord, m);
    chk("vsigned", vsigned, exp_signed(s, m));
  endtask : chk_vert
  task automatic blank();
    @(posedge mclk);
    vblank <= 1'b1;
    repeat (4) @(posedge mclk);
    vblank <= 1'b0;
    settle();
  endtask : blank
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    vblank = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk("rst auto", {auto_thr, 2'h0, thr}, {1'b1, 2'h0, SDCUR_THR_AUTO});
    chk("rst en", {cursor_en, ink_en, vcoord}, 32'h0);
    chk("hresp", hresp, SDCUR_HRESP_OKAY);
    $display("test reset done");
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 6; k++) begin
        v = 8'(rnd());
        if (r == 0) v = 8'hFF;
        wr(cidx[k], v);
        xfer(cidx[k], 1'b0, 32'h0, rd);
        chk("colour rd", rd, v & cmsk[k]);
        settle();
        chk("colour out", col_out(k), v & cmsk[k]);
      end
    end
    $display("test colours done");
    for (int r = 0; r < 4; r++) begin
      v = (r == 0) ? 8'h00 : ((r == 1) ? 8'hFF : 8'(rnd()));
      wr(SDCUR_IDX_THR, v);
      settle();
      chk("thr auto", auto_thr, (v[5:0] == 6'h0));
      chk("thr", thr, (v[5:0] == 6'h0) ? SDCUR_THR_AUTO : v[5:0]);
    end
    $display("test threshold done");
    xfer(8'h81, 1'b1, 32'hFF, rd);
    xfer(8'h81, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    $display("test unmapped done");
    wr(SDCUR_IDX_MODE, {6'h0, SDCUR_MODE_CURSOR});
    a_s = 1'b0;
    a_m = 10'h0;
    for (int r = 0; r < 4; r++) begin
      ylo = 8'(rnd());
      yhi = {r[0], 7'(rnd())};
      if (r[0]) begin
        ylo = ylo & 8'h3F;
        yhi[1:0] = 2'h0;
      end
      wr(SDCUR_IDX_YLO, ylo);
      wr(SDCUR_IDX_XLO, ylo);
      blank();
      chk_vert(a_s, a_m);
      wr(SDCUR_IDX_XHI, yhi);
      wr(SDCUR_IDX_YHI, yhi);
      xfer(SDCUR_IDX_YHI, 1'b0, 32'h0, rd);
      chk("yhi rd", rd, yhi & SDCUR_HI_MASK);
      xfer(SDCUR_IDX_STAT, 1'b0, 32'h0, rd);
      chk("pending", rd, 32'h1);
      settle();
      chk_vert(a_s, a_m);
      blank();
      xfer(SDCUR_IDX_STAT, 1'b0, 32'h0, rd);
      chk("cleared", rd, 32'h0);
      a_s = yhi[7];
      a_m = {yhi[1:0], ylo};
      chk_vert(a_s, a_m);
      chk("hcoord", {hsign, hcoord}, {a_s, a_m});
    end
    $display("test position done");
    for (int m = 0; m < 4; m++) begin
      wr(SDCUR_IDX_MODE, m[7:0]);
      settle();
      chk("cursor_en", cursor_en, (m == 1));
      chk("ink_en", ink_en, (m == 2));
      chk("gated y", {vsign, vcoord}, (m == 1) ? {a_s, a_m} : 11'h0);
    end
    wr(SDCUR_IDX_MODE, {6'h0, SDCUR_MODE_INK});
    wr(SDCUR_IDX_XLO, 8'h00);
    wr(SDCUR_IDX_XHI, 8'h00);
    wr(SDCUR_IDX_YLO, 8'h00);
    wr(SDCUR_IDX_YHI, 8'h00);
    blank();
    chk("ink en", ink_en, 1'b1);
    chk_vert(1'b0, 10'h0);
    $display("test modes done");
    close_out();
  end
endmodule : sdcur_regs_tb
